// File: core/fscd_pkg.sv
// Shared opcodes, reset values, states and carrier types of the setting command decoder.
package fscd_pkg;

   // Command opcodes.
   localparam logic [7:0] OP_LATCH_SET = 8'h06;
   localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_CONFIG_READ = 8'h15;
   localparam logic [7:0] OP_STATUS_CONFIG_WRITE = 8'h01;
   localparam logic [7:0] OP_UPPER_ADDR_READ = 8'hc8;
   localparam logic [7:0] OP_UPPER_ADDR_WRITE = 8'hc5;
   localparam logic [7:0] OP_PROTECT_SCHEME_SELECT = 8'h68;
   localparam logic [7:0] OP_QUAD_ENTER = 8'h35;
   localparam logic [7:0] OP_QUAD_LEAVE = 8'hf5;
   localparam logic [7:0] OP_WIDE_ADDR_ENTER = 8'hb7;
   localparam logic [7:0] OP_WIDE_ADDR_LEAVE = 8'he9;
   localparam logic [7:0] OP_WRITE_OP_PAUSE = 8'hb0;
   localparam logic [7:0] OP_WRITE_OP_CONTINUE = 8'h30;
   localparam logic [7:0] OP_DEEP_SLEEP_ENTER = 8'hb9;
   localparam logic [7:0] OP_DEEP_SLEEP_EXIT = 8'hab;

   // Register reset values and the status bit that mirrors the write permit latch.
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] CONFIG_RST = 8'h00;
   localparam logic [7:0] UPPER_ADDR_RST = 8'h00;
   localparam int STAT_LATCH_BIT = 1;

   // Bits moved per link clock edge, and the pins that drive read data.
   localparam logic [3:0] STEP_SINGLE = 4'h1;
   localparam logic [3:0] STEP_QUAD = 4'h4;
   localparam logic [3:0] OE_SINGLE = 4'h2;
   localparam logic [3:0] OE_QUAD = 4'hf;
   localparam logic [3:0] OE_NONE = 4'h0;
   localparam logic [1:0] BYTES_ONE = 2'h1;
   localparam logic [1:0] BYTES_TWO = 2'h2;
   localparam logic [1:0] BYTES_MAX = 2'h3;

   typedef enum logic [1:0] {ST_IDLE, ST_DATA_IN, ST_DATA_OUT, ST_IGNORE} fscd_state_t;

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] cfg;
      logic [7:0] upper_addr;
   } fscd_regs_t;

   typedef struct packed {
      logic write_permit_latch;
      logic four_line_command_mode;
      logic wide_address_flag;
      logic block_protect;
      logic deep_sleep;
   } fscd_flags_t;

   localparam fscd_regs_t REGS_RST = '{STATUS_RST, CONFIG_RST, UPPER_ADDR_RST};
   localparam fscd_flags_t FLAGS_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage

// File: core/fscd_decoder.sv
// Serial link decoder for the register and setting commands of the flash device.
//
// Summary of operation
// - Opcode 06 sets the write permit latch, in either command mode.
// - Opcode 04 clears the write permit latch, in either command mode.
// - Opcode 05 shifts out the status register with no address bytes.
// - Opcode 15 shifts out the configuration register with no address bytes.
// - Opcode 01 takes one or two bytes: status, then optional configuration.
// - Opcode C8 reads the upper address register; C5 writes exactly one byte.
// - Opcode 68 selects and enables individual block protection, no further bytes.
// - Opcode 35 enters four-line mode, in either command mode.
// - Opcode F5 returns to single-line mode, in either command mode.
// - Opcode B7 enters four-byte addressing and sets the wide address flag.
// - Opcode E9 leaves four-byte addressing and clears the wide address flag.
// - Opcode B0 suspends program or erase, in either command mode.
// - B9 enters deep sleep, AB leaves it, 30 resumes program or erase.
module fscd_decoder
   import fscd_pkg::*;
(
   input wire logic CLK_IN, // System clock, 50 MHz.
   input wire logic SYS_RST_IN, // Asynchronous reset, active high.
   input wire logic CS_N_IN, // Chip select from host, active low.
   input wire logic SCLK_IN, // Serial clock from host.
   input wire logic [3:0] SIO_IN, // Serial data pins, input side.
   output logic [3:0] SIO_OUT, // Serial data pins, output side.
   output logic [3:0] SIO_OE_OUT, // Serial data pin drive enables.
   output logic [7:0] STATUS_OUT, // Status register.
   output logic [7:0] CONFIG_OUT, // Configuration register.
   output logic [7:0] UPPER_ADDR_OUT, // Extended address register.
   output logic WRITE_PERMIT_OUT, // Write permit latch.
   output logic FOUR_LINE_MODE_OUT, // Four-line command mode active.
   output logic WIDE_ADDR_OUT, // Four-byte addressing flag.
   output logic BLOCK_PROTECT_OUT, // Individual block protection enabled.
   output logic DEEP_SLEEP_OUT, // Deep power-down active.
   output logic PAUSE_OUT, // One-cycle pulse: suspend program or erase.
   output logic CONTINUE_OUT // One-cycle pulse: resume program or erase.
);
   // Synchronisers for the host pins; the third clock stage only feeds edge detection.
   logic sclk_s1, sclk_s2, sclk_s3;
   logic cs_s1, cs_s2;
   logic [3:0] sio_s1, sio_s2;
   always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_s3 <= 1'b0;
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         sio_s1 <= 4'h0;
         sio_s2 <= 4'h0;
      end else begin
         sclk_s1 <= SCLK_IN;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         cs_s1 <= CS_N_IN;
         cs_s2 <= cs_s1;
         sio_s1 <= SIO_IN;
         sio_s2 <= sio_s1;
      end
   end
   fscd_state_t state, next_state;
   fscd_regs_t regs, next_regs;
   fscd_flags_t flags, next_flags;
   logic [7:0] opcode, next_opcode;
   logic [7:0] sh, next_sh;
   logic [7:0] out_sh, next_out_sh;
   logic [7:0] buf0, next_buf0;
   logic [7:0] buf1, next_buf1;
   logic [2:0] cnt, next_cnt;
   logic [1:0] nbytes, next_nbytes;
   logic [3:0] sio_out, next_sio_out;
   logic [3:0] sio_oe, next_sio_oe;
   logic pause, next_pause;
   logic resume, next_resume;
   logic rise, fall, cs_hi, byte_done;
   logic [3:0] step, sum;
   logic [7:0] shifted;
   // Value shifted out for a read opcode; the latch shows through its status bit.
   function automatic logic [7:0] read_view(input logic [7:0] op, input fscd_regs_t r, input logic latch);
      logic [7:0] v;
      v = r.status;
      v[STAT_LATCH_BIT] = latch;
      if (op == OP_CONFIG_READ) begin
         v = r.cfg;
      end else if (op == OP_UPPER_ADDR_READ) begin
         v = r.upper_addr;
      end
      return v;
   endfunction
   assign rise = sclk_s2 & ~sclk_s3;
   assign fall = ~sclk_s2 & sclk_s3;
   assign cs_hi = cs_s2;
   assign step = flags.four_line_command_mode ? STEP_QUAD : STEP_SINGLE;
   assign sum = {1'b0, cnt} + step;
   assign byte_done = rise && sum[3];
   assign shifted = flags.four_line_command_mode ? {sh[3:0], sio_s2} : {sh[6:0], sio_s2[0]};
   always_comb begin
      next_state = state;
      next_regs = regs;
      next_flags = flags;
      next_opcode = opcode;
      next_sh = sh;
      next_out_sh = out_sh;
      next_buf0 = buf0;
      next_buf1 = buf1;
      next_cnt = cnt;
      next_nbytes = nbytes;
      next_sio_out = sio_out;
      next_sio_oe = sio_oe;
      next_pause = 1'b0;
      next_resume = 1'b0;
      if (cs_hi) begin
         // Writes commit when the frame ends, and only with a complete byte count.
         if (state == ST_DATA_IN) begin
            if (opcode == OP_STATUS_CONFIG_WRITE && (nbytes == BYTES_ONE || nbytes == BYTES_TWO)) begin
               next_regs.status = buf0;
               if (nbytes == BYTES_TWO) begin
                  next_regs.cfg = buf1;
               end
               next_flags.write_permit_latch = 1'b0;
            end
            if (opcode == OP_UPPER_ADDR_WRITE && nbytes == BYTES_ONE) begin
               next_regs.upper_addr = buf0;
               next_flags.write_permit_latch = 1'b0;
            end
         end
         next_state = ST_IDLE;
         next_cnt = 3'h0;
         next_nbytes = 2'h0;
         next_sio_oe = OE_NONE;
      end else if (rise && (state == ST_IDLE || state == ST_DATA_IN)) begin
         next_sh = shifted;
         next_cnt = sum[2:0];
         if (sum[3] && state == ST_DATA_IN) begin
            if (nbytes == 2'h0) begin
               next_buf0 = shifted;
            end else if (nbytes == BYTES_ONE) begin
               next_buf1 = shifted;
            end
            if (nbytes != BYTES_MAX) begin
               next_nbytes = nbytes + BYTES_ONE;
            end
         end else if (sum[3]) begin
            next_opcode = shifted;
            next_state = ST_IGNORE;
            if (flags.deep_sleep) begin
               if (shifted == OP_DEEP_SLEEP_EXIT) begin
                  next_flags.deep_sleep = 1'b0;
               end
            end else begin
               unique case (shifted)
                  OP_LATCH_SET: next_flags.write_permit_latch = 1'b1;
                  OP_LATCH_CLEAR: next_flags.write_permit_latch = 1'b0;
                  OP_STATUS_READ, OP_CONFIG_READ, OP_UPPER_ADDR_READ: begin
                     next_state = ST_DATA_OUT;
                     next_out_sh = read_view(shifted, regs, flags.write_permit_latch);
                  end
                  OP_STATUS_CONFIG_WRITE, OP_UPPER_ADDR_WRITE: begin
                     if (flags.write_permit_latch) begin
                        next_state = ST_DATA_IN;
                     end
                  end
                  OP_PROTECT_SCHEME_SELECT: next_flags.block_protect = 1'b1;
                  OP_QUAD_ENTER: next_flags.four_line_command_mode = 1'b1;
                  OP_QUAD_LEAVE: next_flags.four_line_command_mode = 1'b0;
                  OP_WIDE_ADDR_ENTER: next_flags.wide_address_flag = 1'b1;
                  OP_WIDE_ADDR_LEAVE: next_flags.wide_address_flag = 1'b0;
                  OP_WRITE_OP_PAUSE: next_pause = 1'b1;
                  OP_WRITE_OP_CONTINUE: next_resume = 1'b1;
                  OP_DEEP_SLEEP_ENTER: next_flags.deep_sleep = 1'b1;
                  default: next_state = ST_IGNORE;
               endcase
            end
         end
      end else if (fall && state == ST_DATA_OUT) begin
         // Read data changes on falling edges and repeats until the frame ends.
         next_sio_out = flags.four_line_command_mode ? out_sh[7:4] : {2'b00, out_sh[7], 1'b0};
         next_sio_oe = flags.four_line_command_mode ? OE_QUAD : OE_SINGLE;
         next_out_sh = flags.four_line_command_mode ? {out_sh[3:0], 4'h0} : {out_sh[6:0], 1'b0};
         next_cnt = sum[2:0];
         if (sum[3]) begin
            next_out_sh = read_view(opcode, regs, flags.write_permit_latch);
         end
      end
   end
   always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         state <= ST_IDLE;
         regs <= REGS_RST;
         flags <= FLAGS_RST;
         opcode <= 8'h00;
         sh <= 8'h00;
         out_sh <= 8'h00;
         buf0 <= 8'h00;
         buf1 <= 8'h00;
         cnt <= 3'h0;
         nbytes <= 2'h0;
         sio_out <= 4'h0;
         sio_oe <= OE_NONE;
         pause <= 1'b0;
         resume <= 1'b0;
      end else begin
         state <= next_state;
         regs <= next_regs;
         flags <= next_flags;
         opcode <= next_opcode;
         sh <= next_sh;
         out_sh <= next_out_sh;
         buf0 <= next_buf0;
         buf1 <= next_buf1;
         cnt <= next_cnt;
         nbytes <= next_nbytes;
         sio_out <= next_sio_out;
         sio_oe <= next_sio_oe;
         pause <= next_pause;
         resume <= next_resume;
      end
   end
   assign SIO_OUT = sio_out;
   assign SIO_OE_OUT = sio_oe;
   assign STATUS_OUT = regs.status;
   assign CONFIG_OUT = regs.cfg;
   assign UPPER_ADDR_OUT = regs.upper_addr;
   assign WRITE_PERMIT_OUT = flags.write_permit_latch;
   assign FOUR_LINE_MODE_OUT = flags.four_line_command_mode;
   assign WIDE_ADDR_OUT = flags.wide_address_flag;
   assign BLOCK_PROTECT_OUT = flags.block_protect;
   assign DEEP_SLEEP_OUT = flags.deep_sleep;
   assign PAUSE_OUT = pause;
   assign CONTINUE_OUT = resume;
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (SYS_RST_IN);
   sequence op_seen(logic [7:0] c);
      byte_done && !cs_hi && state == ST_IDLE && !flags.deep_sleep && shifted == c;
   endsequence

   sequence frame_end_in;
      cs_hi && state == ST_DATA_IN;
   endsequence

   latch_set_a: assert property (op_seen(OP_LATCH_SET) |=> flags.write_permit_latch)
      else $error("latch not set after set opcode");
   latch_clear_a: assert property (op_seen(OP_LATCH_CLEAR) |=> !flags.write_permit_latch)
      else $error("latch not cleared after clear opcode");
   status_load_a: assert property (op_seen(OP_STATUS_READ) |=> state == ST_DATA_OUT
      && out_sh == {$past(regs.status[7:2]), $past(flags.write_permit_latch), $past(regs.status[0])})
      else $error("status read not loaded");
   config_load_a: assert property (op_seen(OP_CONFIG_READ) |=> state == ST_DATA_OUT && out_sh == regs.cfg)
      else $error("config read not loaded");
   status_write_a: assert property (frame_end_in and (opcode == OP_STATUS_CONFIG_WRITE && nbytes == BYTES_TWO)
      |=> regs.status == $past(buf0) && regs.cfg == $past(buf1) && !flags.write_permit_latch)
      else $error("status and config write not committed");
   upper_write_a: assert property (frame_end_in and (opcode == OP_UPPER_ADDR_WRITE && nbytes == BYTES_ONE)
      |=> regs.upper_addr == $past(buf0))
      else $error("upper address write not committed");
   block_protect_a: assert property (op_seen(OP_PROTECT_SCHEME_SELECT) |=> flags.block_protect)
      else $error("block protection not enabled");
   quad_enter_a: assert property (op_seen(OP_QUAD_ENTER) |=> flags.four_line_command_mode ##1
      flags.four_line_command_mode)
      else $error("four-line mode not entered");
   quad_leave_a: assert property (op_seen(OP_QUAD_LEAVE) |=> !flags.four_line_command_mode)
      else $error("four-line mode not left");
   wide_enter_a: assert property (op_seen(OP_WIDE_ADDR_ENTER) |=> flags.wide_address_flag)
      else $error("wide address flag not set");
   wide_leave_a: assert property (op_seen(OP_WIDE_ADDR_LEAVE) |=> !flags.wide_address_flag)
      else $error("wide address flag not cleared");
   pause_pulse_a: assert property (op_seen(OP_WRITE_OP_PAUSE) |=> pause ##1 !pause)
      else $error("suspend pulse wrong");
   sleep_wake_a: assert property (byte_done && !cs_hi && state == ST_IDLE && flags.deep_sleep
      && shifted == OP_DEEP_SLEEP_EXIT |=> !flags.deep_sleep)
      else $error("deep sleep not left");
   write_gate_a: assert property ((op_seen(OP_STATUS_CONFIG_WRITE) or op_seen(OP_UPPER_ADDR_WRITE))
      ##0 !flags.write_permit_latch |=> state == ST_IGNORE)
      else $error("write taken without latch");
   single_shift_a: assert property (rise && !cs_hi && state == ST_IDLE && !flags.four_line_command_mode
      |=> sh == {$past(sh[6:0]), $past(sio_s2[0])})
      else $error("single-line shift wrong");
   ignore_hold_a: assert property (state == ST_IGNORE && !cs_hi |=> state == ST_IGNORE && sio_oe == OE_NONE)
      else $error("ignored frame left early");

endmodule

// File: tb/fscd_host.sv
// Host link model that drives chip select, serial clock and data pins of the decoder.
module fscd_host (
   input wire logic [3:0] sio_wire_in, // Resolved level of the data pins.
   output logic cs_n_out, // Chip select, active low.
   output logic sclk_out, // Serial clock, idles low.
   output logic [3:0] sio_out // Host drive of the data pins.
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      sio_out = 4'h0;
   end

   task automatic frame_start();
      cs_n_out = 1'b0;
      #80;
   endtask

   task automatic send_byte(input logic quad, input logic [7:0] data);
      int i;
      for (i = 0; i < (quad ? 2 : 8); i++) begin
         sclk_out = 1'b0;
         sio_out = quad ? data[7 - 4 * i -: 4] : {3'h0, data[7 - i]};
         #80;
         sclk_out = 1'b1;
         #80;
      end
   endtask

   // Samples late in the high phase, since read data follows the falling edge by three cycles.
   task automatic recv_byte(input logic quad, output logic [7:0] data);
      int i;
      data = 8'h00;
      for (i = 0; i < (quad ? 2 : 8); i++) begin
         sclk_out = 1'b0;
         sio_out = ~sio_out;
         #80;
         sclk_out = 1'b1;
         #75;
         data = quad ? {data[3:0], sio_wire_in} : {data[6:0], sio_wire_in[1]};
         #5;
      end
   endtask

   // Released pins show the inverse of the last value, so stale data cannot pass.
   task automatic frame_stop();
      sclk_out = 1'b0;
      #80;
      cs_n_out = 1'b1;
      sio_out = ~sio_out;
      #160;
   endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the setting command decoder.
module tb_top import fscd_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct packed {
      logic [7:0] op;
      logic quad;
      fscd_flags_t flags;
   } fscd_row_t;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cs_n, sclk, wp, four, wide, bp, ds, pause, cont;
   logic [3:0] host_sio, sio_wire, sio_do, sio_oe;
   logic [7:0] status, conf, upper;
   fscd_flags_t flags;
   int error_cnt = 0;
   int n_checks = 0;
   int pause_cnt = 0;
   int cont_cnt = 0;
   fscd_row_t rows[19] = '{'{8'h06, 1'b0, 5'h10}, '{8'h04, 1'b0, 5'h00}, '{8'hf5, 1'b0, 5'h00},
      '{8'hb7, 1'b0, 5'h04}, '{8'he9, 1'b0, 5'h00}, '{8'h68, 1'b0, 5'h02}, '{8'h35, 1'b0, 5'h0a},
      '{8'h35, 1'b1, 5'h0a}, '{8'h06, 1'b1, 5'h1a}, '{8'hb7, 1'b1, 5'h1e}, '{8'hb9, 1'b1, 5'h1f},
      '{8'h04, 1'b1, 5'h1f}, '{8'hab, 1'b1, 5'h1e}, '{8'h04, 1'b1, 5'h0e}, '{8'he9, 1'b1, 5'h0a},
      '{8'hf5, 1'b1, 5'h02}, '{8'hb0, 1'b0, 5'h02}, '{8'h30, 1'b0, 5'h02}, '{8'h77, 1'b0, 5'h02}};

   always #10 clk = ~clk;

   assign sio_wire = (sio_oe & sio_do) | (~sio_oe & host_sio);
   assign flags = {wp, four, wide, bp, ds};

   always @(posedge clk) begin
      if (pause === 1'b1) pause_cnt++;
      if (cont === 1'b1) cont_cnt++;
   end

   fscd_decoder fscd_decoder_inst (.CLK_IN(clk), .SYS_RST_IN(rst), .CS_N_IN(cs_n), .SCLK_IN(sclk),
      .SIO_IN(sio_wire), .SIO_OUT(sio_do), .SIO_OE_OUT(sio_oe), .STATUS_OUT(status), .CONFIG_OUT(conf),
      .UPPER_ADDR_OUT(upper), .WRITE_PERMIT_OUT(wp), .FOUR_LINE_MODE_OUT(four), .WIDE_ADDR_OUT(wide),
      .BLOCK_PROTECT_OUT(bp), .DEEP_SLEEP_OUT(ds), .PAUSE_OUT(pause), .CONTINUE_OUT(cont));

   fscd_host fscd_host_inst (.sio_wire_in(sio_wire), .cs_n_out(cs_n), .sclk_out(sclk), .sio_out(host_sio));

   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmd(input logic q, input logic [7:0] op, input int n, input logic [15:0] d);
      @(posedge clk);
      #2;
      fscd_host_inst.frame_start();
      fscd_host_inst.send_byte(q, op);
      if (n > 0) fscd_host_inst.send_byte(q, d[15:8]);
      if (n > 1) fscd_host_inst.send_byte(q, d[7:0]);
      fscd_host_inst.frame_stop();
   endtask

   // Reads two bytes, since a read repeats the register until chip select rises.
   task automatic rd(input logic q, input logic [7:0] op, input logic [7:0] exp);
      logic [7:0] b;
      @(posedge clk);
      #2;
      fscd_host_inst.frame_start();
      fscd_host_inst.send_byte(q, op);
      repeat (2) begin
         fscd_host_inst.recv_byte(q, b);
         check(b, exp);
         check(sio_oe, q ? OE_QUAD : OE_SINGLE);
      end
      fscd_host_inst.frame_stop();
      check(sio_oe, OE_NONE);
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      #300000;
      error_cnt++;
      conclude();
   end

   initial begin
      repeat (20) @(posedge clk);
      #2 rst = 1'b0;
      repeat (4) @(posedge clk);
      #2;
      check({sio_oe, status, conf, upper, flags}, 40'h0);
      foreach (rows[i]) begin
         cmd(rows[i].quad, rows[i].op, 0, 16'h0);
         check(flags, rows[i].flags);
      end
      check(pause_cnt, 1);
      check(cont_cnt, 1);
      cmd(1'b0, 8'h01, 2, 16'h5c3c);
      check({status, conf}, 16'h0000);
      cmd(1'b0, 8'h06, 0, 16'h0);
      cmd(1'b0, 8'h01, 2, 16'h5c3c);
      check({status, conf, wp}, {16'h5c3c, 1'b0});
      cmd(1'b0, 8'h06, 0, 16'h0);
      cmd(1'b0, 8'h01, 1, 16'ha000);
      check({status, conf}, 16'ha03c);
      cmd(1'b0, 8'h06, 0, 16'h0);
      cmd(1'b0, 8'hc5, 2, 16'h1122);
      check(upper, 8'h00);
      cmd(1'b0, 8'h06, 0, 16'h0);
      cmd(1'b0, 8'hc5, 1, 16'ha700);
      check(upper, 8'ha7);
      rd(1'b0, 8'h05, 8'ha0);
      rd(1'b0, 8'h15, 8'h3c);
      rd(1'b0, 8'hc8, 8'ha7);
      cmd(1'b0, 8'h35, 0, 16'h0);
      cmd(1'b1, 8'h06, 0, 16'h0);
      rd(1'b1, 8'h05, 8'ha2);
      rd(1'b1, 8'hc8, 8'ha7);
      @(posedge clk);
      #2 rst = 1'b1;
      repeat (3) @(posedge clk);
      #2;
      check({sio_oe, status, conf, upper, flags}, 40'h0);
      rst = 1'b0;
      repeat (4) @(posedge clk);
      rd(1'b0, 8'h05, 8'h00);
      conclude();
   end
endmodule
